/* File: hw/amc_top.sv */
// Audio master-clock output stage: registers, dividers, source select and output pins.
// Assumes synthesizer and external clocks arrive as levels synchronous to mclk,
// and that the processor bus presents one access per cycle with read data taken a cycle later.
`include "amc_params.svh"

// Functional notes
// - Three bytes form second synthesizer 24-bit word.
// - Word bits 23:16 held, read/write, reset zero.
// - Second synthesizer divided by field plus one.
// - First synthesizer divided by field plus one.
// - External clock divided by 3-bit field plus one.
// - Dividers run only while divider enable set.
// - Second output driven when bit 7, else low.
// - First output driven when bit 6, else low.
// - Bits 4:3 choose first output's source.
// - Bits 1:0 choose second output's source.
// - Reserved bits read-only, read as zero.
// - Edge counter captured into two bytes per frame.
module amc_top
	import amc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Processor register bus.
	input wire logic [15:0] mcu_addr,
	input wire logic mcu_wr,
	input wire logic mcu_rd,
	input wire logic [7:0] mcu_wdata,
	output logic [7:0] mcu_rdata,
	// Clock sources and frame marker.
	input wire logic first_synth_clock,
	input wire logic second_synth_clock,
	input wire logic ext_master_clock_in,
	input wire logic usb_sof,
	input wire logic capture_use_second,
	// Synthesizer programming.
	output logic [23:0] second_synth_freq_word,
	// Master-clock output pins.
	output logic first_master_clock_out,
	output logic second_master_clock_out
);

	amc_bus_req_t req;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] div1_reg, div1_next;
	logic [7:0] div2_reg, div2_next;
	logic [7:0] frq_hi_reg, frq_hi_next;
	logic [7:0] frq_mid_reg, frq_mid_next;
	logic [7:0] frq_lo_reg, frq_lo_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [15:0] captured;

	assign req = '{addr: mcu_addr, wr: mcu_wr, rd: mcu_rd, wdata: mcu_wdata};

	// Register writes; reserved bits are masked so they always read as zero.
	always_comb
	begin
		ctrl_next = ctrl_reg;
		div1_next = div1_reg;
		div2_next = div2_reg;
		frq_hi_next = frq_hi_reg;
		frq_mid_next = frq_mid_reg;
		frq_lo_next = frq_lo_reg;
		if (req.wr)
		begin
			case (req.addr)
				`AMC_ADDR_CTRL: ctrl_next = req.wdata & `AMC_MASK_CTRL;
				`AMC_ADDR_DIV1: div1_next = req.wdata & `AMC_MASK_DIV1;
				`AMC_ADDR_DIV2: div2_next = req.wdata & `AMC_MASK_DIV2;
				`AMC_ADDR_FRQ2_HI: frq_hi_next = req.wdata;
				`AMC_ADDR_FRQ2_MID: frq_mid_next = req.wdata;
				`AMC_ADDR_FRQ2_LO: frq_lo_next = req.wdata;
				default: ;
			endcase
		end
	end

	// Read data is registered; unmapped addresses and idle cycles return zero.
	always_comb
	begin
		rdata_next = `AMC_RST_BYTE;
		if (req.rd)
		begin
			case (req.addr)
				`AMC_ADDR_CTRL: rdata_next = ctrl_reg;
				`AMC_ADDR_DIV1: rdata_next = div1_reg;
				`AMC_ADDR_DIV2: rdata_next = div2_reg;
				`AMC_ADDR_CAP_HI: rdata_next = captured[15:8];
				`AMC_ADDR_CAP_LO: rdata_next = captured[7:0];
				`AMC_ADDR_FRQ2_HI: rdata_next = frq_hi_reg;
				`AMC_ADDR_FRQ2_MID: rdata_next = frq_mid_reg;
				`AMC_ADDR_FRQ2_LO: rdata_next = frq_lo_reg;
				default: rdata_next = `AMC_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `AMC_RST_BYTE;
			div1_reg <= `AMC_RST_BYTE;
			div2_reg <= `AMC_RST_BYTE;
			frq_hi_reg <= `AMC_RST_BYTE;
			frq_mid_reg <= `AMC_RST_BYTE;
			frq_lo_reg <= `AMC_RST_BYTE;
			rdata_reg <= `AMC_RST_BYTE;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			div1_reg <= div1_next;
			div2_reg <= div2_next;
			frq_hi_reg <= frq_hi_next;
			frq_mid_reg <= frq_mid_next;
			frq_lo_reg <= frq_lo_next;
			rdata_reg <= rdata_next;
		end
	end

	assign mcu_rdata = rdata_reg;
	assign second_synth_freq_word = {frq_hi_reg, frq_mid_reg, frq_lo_reg};

	// The three dividers share one enable bit.
	amc_srcs_t divided;
	logic div_en;

	assign div_en = ctrl_reg[`AMC_CTRL_DIV_EN];

	amc_clk_div u_div_syn1
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.src(first_synth_clock),
		.enable(div_en),
		.ratio(div1_reg[`AMC_DIVM_HI:`AMC_DIVM_LO]),
		.out(divided.syn1)
	);

	amc_clk_div u_div_syn2
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.src(second_synth_clock),
		.enable(div_en),
		.ratio(div2_reg[`AMC_DIVM_HI:`AMC_DIVM_LO]),
		.out(divided.syn2)
	);

	amc_clk_div u_div_ext
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.src(ext_master_clock_in),
		.enable(div_en),
		.ratio({1'b0, div1_reg[`AMC_DIVI_HI:`AMC_DIVI_LO]}),
		.out(divided.ext)
	);

	// Requested source and enable for each pin, straight from the control register.
	logic [1:0] sel1_req, sel2_req;
	logic en1_req, en2_req;

	assign sel1_req = {ctrl_reg[`AMC_CTRL_OUT1_SEL_HI], ctrl_reg[`AMC_CTRL_OUT1_SEL_LO]};
	assign sel2_req = {ctrl_reg[`AMC_CTRL_OUT2_SEL_HI], ctrl_reg[`AMC_CTRL_OUT2_SEL_LO]};
	assign en1_req = ctrl_reg[`AMC_CTRL_OUT1_EN];
	assign en2_req = ctrl_reg[`AMC_CTRL_OUT2_EN];

	// Active selections change only while both the old and the new clock are low,
	// so a pin never shows a shortened high phase. A stopped source that rests high
	// delays the switch until it falls; software sees that as a late change, not a glitch.
	logic [1:0] sel1_reg, sel1_next, sel2_reg, sel2_next;
	logic en1_reg, en1_next, en2_reg, en2_next;
	logic pin1_reg, pin1_next, pin2_reg, pin2_next;
	logic cur1, cur2, new1, new2;

	assign cur1 = amc_pick(sel1_reg, divided);
	assign cur2 = amc_pick(sel2_reg, divided);
	assign new1 = amc_pick(sel1_req, divided);
	assign new2 = amc_pick(sel2_req, divided);

	always_comb
	begin
		sel1_next = sel1_reg;
		sel2_next = sel2_reg;
		en1_next = en1_reg;
		en2_next = en2_reg;
		if (!cur1 && !new1)
			sel1_next = sel1_req;
		if (!cur1)
			en1_next = en1_req;
		if (!cur2 && !new2)
			sel2_next = sel2_req;
		if (!cur2)
			en2_next = en2_req;
		pin1_next = en1_next & amc_pick(sel1_next, divided);
		pin2_next = en2_next & amc_pick(sel2_next, divided);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel1_reg <= 2'h0;
			sel2_reg <= 2'h0;
			en1_reg <= 1'b0;
			en2_reg <= 1'b0;
			pin1_reg <= 1'b0;
			pin2_reg <= 1'b0;
		end
		else
		begin
			sel1_reg <= sel1_next;
			sel2_reg <= sel2_next;
			en1_reg <= en1_next;
			en2_reg <= en2_next;
			pin1_reg <= pin1_next;
			pin2_reg <= pin2_next;
		end
	end

	assign first_master_clock_out = pin1_reg;
	assign second_master_clock_out = pin2_reg;

	// Edge counter on the chosen output pin, captured at each start of frame.
	amc_capture u_capture
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_level(capture_use_second ? pin2_reg : pin1_reg),
		.sof(usb_sof),
		.captured(captured)
	);

	property p_pin2_off;
		@(posedge mclk) disable iff (!rst_n) !en2_reg |-> !second_master_clock_out;
	endproperty
	a_pin2_off: assert property (p_pin2_off) else $error("Second output high while disabled.");

	property p_pin1_follow;
		@(posedge mclk) disable iff (!rst_n)
			en1_reg && $stable(sel1_reg) |-> first_master_clock_out == amc_pick(sel1_reg, $past(divided));
	endproperty
	a_pin1_follow: assert property (p_pin1_follow) else $error("First output not following its source.");

	property p_sel1_ext;
		@(posedge mclk) disable iff (!rst_n)
			en1_reg && sel1_reg[0] && $stable(sel1_reg) |-> first_master_clock_out == $past(divided.ext);
	endproperty
	a_sel1_ext: assert property (p_sel1_ext) else $error("Code x1 did not pick the external clock.");

	property p_sel2_syn2;
		@(posedge mclk) disable iff (!rst_n)
			en2_reg && sel2_reg == 2'h2 && $stable(sel2_reg) |-> second_master_clock_out == $past(divided.syn2);
	endproperty
	a_sel2_syn2: assert property (p_sel2_syn2) else $error("Code 10 did not pick the second synthesizer.");

	property p_no_runt;
		@(posedge mclk) disable iff (!rst_n) $changed(sel1_reg) |-> !$past(cur1) && !first_master_clock_out;
	endproperty
	a_no_runt: assert property (p_no_runt) else $error("Source switched while the clock was high.");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_n)
			!ctrl_reg[5] && !div1_reg[3] && div2_reg[3:0] == 4'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("A reserved bit became set.");

	property p_frq_write;
		@(posedge mclk) disable iff (!rst_n)
			mcu_wr && mcu_addr == `AMC_ADDR_FRQ2_HI |=> second_synth_freq_word[23:16] == $past(mcu_wdata);
	endproperty
	a_frq_write: assert property (p_frq_write) else $error("Frequency high byte did not take the write.");

	property p_frq_read;
		@(posedge mclk) disable iff (!rst_n)
			mcu_rd && mcu_addr == `AMC_ADDR_FRQ2_LO |=> mcu_rdata == $past(second_synth_freq_word[7:0]);
	endproperty
	a_frq_read: assert property (p_frq_read) else $error("Low frequency byte read back wrong.");

	property p_cap_read;
		@(posedge mclk) disable iff (!rst_n)
			mcu_rd && mcu_addr == `AMC_ADDR_CAP_HI |=> mcu_rdata == $past(captured[15:8]);
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("Capture high byte read back wrong.");

	property p_pin1_off;
		@(posedge mclk) disable iff (!rst_n) !en1_reg |-> !first_master_clock_out;
	endproperty
	a_pin1_off: assert property (p_pin1_off) else $error("First output high while disabled.");

	property p_sel1_syn1;
		@(posedge mclk) disable iff (!rst_n)
			en1_reg && sel1_reg == 2'h0 && $stable(sel1_reg) |-> first_master_clock_out == $past(divided.syn1);
	endproperty
	a_sel1_syn1: assert property (p_sel1_syn1) else $error("Code 00 did not pick the first synthesizer.");

	property p_no_runt2;
		@(posedge mclk) disable iff (!rst_n) $changed(sel2_reg) |-> !$past(cur2) && !second_master_clock_out;
	endproperty
	a_no_runt2: assert property (p_no_runt2) else $error("Second source switched while its clock was high.");

	property p_ctrl_write;
		@(posedge mclk) disable iff (!rst_n)
			mcu_wr && mcu_addr == `AMC_ADDR_CTRL |=> ctrl_reg == ($past(mcu_wdata) & `AMC_MASK_CTRL);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("Control register did not take the write.");

endmodule : amc_top

/* File: hw/amc_params.svh */
// Constants for the audio master-clock select and divide block.
// Assumes an 8-bit processor data bus with 16-bit memory-mapped addresses.
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// Register byte addresses on the processor data bus.
`define AMC_ADDR_CTRL 16'hffe1
`define AMC_ADDR_DIV1 16'hffe2
`define AMC_ADDR_CAP_HI 16'hffe3
`define AMC_ADDR_CAP_LO 16'hffe4
`define AMC_ADDR_DIV2 16'hfff6
`define AMC_ADDR_FRQ2_HI 16'hfff7
`define AMC_ADDR_FRQ2_MID 16'hfff8
`define AMC_ADDR_FRQ2_LO 16'hfff9

// Reset values.
`define AMC_RST_BYTE 8'h00

// Writable-bit masks; cleared bits are reserved and read as zero.
`define AMC_MASK_CTRL 8'hdf
`define AMC_MASK_DIV1 8'hf7
`define AMC_MASK_DIV2 8'hf0

// Field positions in the control register.
`define AMC_CTRL_OUT2_EN 7
`define AMC_CTRL_OUT1_EN 6
`define AMC_CTRL_OUT1_SEL_HI 4
`define AMC_CTRL_OUT1_SEL_LO 3
`define AMC_CTRL_DIV_EN 2
`define AMC_CTRL_OUT2_SEL_HI 1
`define AMC_CTRL_OUT2_SEL_LO 0

// Field positions in the divider registers.
`define AMC_DIVM_HI 7
`define AMC_DIVM_LO 4
`define AMC_DIVI_HI 2
`define AMC_DIVI_LO 0

`endif

/* File: hw/amc_pkg.sv */
// Types shared by the audio master-clock select and divide block.
// Assumes the constants header is compiled alongside.
package amc_pkg;

	// One processor bus access, as seen in a single cycle.
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} amc_bus_req_t;

	// The three divided clocks that an output may pick from.
	typedef struct packed {
		logic syn1;
		logic ext;
		logic syn2;
	} amc_srcs_t;

	// Source code x1 picks the external input, 10 the second synthesizer, 00 the first.
	function automatic logic amc_pick(input logic [1:0] sel, input amc_srcs_t s);
		amc_pick = sel[0] ? s.ext : (sel[1] ? s.syn2 : s.syn1);
	endfunction : amc_pick

	// High-phase length of a divided clock, in source periods: ceil of half the divide-by, code plus one.
	function automatic logic [4:0] amc_half(input logic [3:0] code);
		amc_half = (5'({1'b0, code}) + 5'h02) >> 1;
	endfunction : amc_half

endpackage : amc_pkg

/* File: hw/amc_clk_div.sv */
// Divide-by-N stage: counts rising edges of a source level and builds the divided clock.
// Assumes the source level is synchronous to mclk and slower than half its rate.
module amc_clk_div
	import amc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Source and control.
	input wire logic src,
	input wire logic enable,
	input wire logic [3:0] ratio,
	// Divided clock.
	output logic out
);

	logic src_reg, src_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [3:0] ratio_reg, ratio_next;
	logic out_reg, out_next;
	logic run_reg, run_next;
	logic rise;

	assign rise = src & ~src_reg;

	// New ratios are taken only at the end of a divided period, so no short pulse appears.
	// Starting and stopping wait until both the divided clock and its source are low,
	// so neither the first nor the last high phase is cut short. A source stopped high
	// therefore delays a stop; the trade is a late stop instead of a runt on the pin.
	always_comb
	begin
		src_next = src;
		run_next = run_reg;
		cnt_next = cnt_reg;
		ratio_next = ratio_reg;
		out_next = 1'b0;
		if (!out_reg && !src)
			run_next = enable;
		if (!run_next)
		begin
			// Parking the count at the ratio makes the first source rise open a full period.
			cnt_next = ratio;
			ratio_next = ratio;
		end
		else
		begin
			if (rise)
			begin
				if (cnt_reg == ratio_reg)
				begin
					cnt_next = 4'h0;
					ratio_next = ratio;
				end
				else
					cnt_next = cnt_reg + 4'h1;
			end
			if (ratio_next == 4'h0)
				out_next = src;
			else
				out_next = 5'({1'b0, cnt_next}) < amc_half(ratio_next);
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_reg <= 1'b0;
			run_reg <= 1'b0;
			cnt_reg <= 4'h0;
			ratio_reg <= 4'h0;
			out_reg <= 1'b0;
		end
		else
		begin
			src_reg <= src_next;
			run_reg <= run_next;
			cnt_reg <= cnt_next;
			ratio_reg <= ratio_next;
			out_reg <= out_next;
		end
	end

	assign out = out_reg;

	property p_div_off;
		@(posedge mclk) disable iff (!rst_n) !run_reg |-> !out;
	endproperty
	a_div_off: assert property (p_div_off) else $error("Divider output high while disabled.");

	property p_run_gate;
		@(posedge mclk) disable iff (!rst_n) !out && !src |=> run_reg == $past(enable);
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("Divider run state did not follow its enable.");

	property p_cnt_bound;
		@(posedge mclk) disable iff (!rst_n) cnt_reg <= ratio_reg;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("Divider count passed its ratio.");

	property p_wrap;
		@(posedge mclk) disable iff (!rst_n) run_reg && rise && cnt_reg == ratio_reg |=> cnt_reg == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Divider did not wrap at its ratio.");

endmodule : amc_clk_div

/* File: hw/amc_capture.sv */
// Free-running 16-bit master-clock edge counter, captured at each start of frame.
// Assumes the counted clock level and the frame pulse are synchronous to mclk.
module amc_capture
	import amc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Counted clock and frame marker.
	input wire logic clk_level,
	input wire logic sof,
	// Captured count.
	output logic [15:0] captured
);

	logic lvl_reg, lvl_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] cap_reg, cap_next;

	// Count rising edges and latch the running count on the frame pulse.
	always_comb
	begin
		lvl_next = clk_level;
		cnt_next = cnt_reg + 16'({15'h0000, clk_level & ~lvl_reg});
		cap_next = sof ? cnt_reg : cap_reg;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			cap_reg <= 16'h0000;
		end
		else
		begin
			lvl_reg <= lvl_next;
			cnt_reg <= cnt_next;
			cap_reg <= cap_next;
		end
	end

	assign captured = cap_reg;

	property p_capture;
		@(posedge mclk) disable iff (!rst_n) sof |=> captured == $past(cnt_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("Frame capture missed the running count.");

endmodule : amc_capture

/* File: tb/amc_codec_model.sv */
// Codec-side partner: makes the three source clock levels and counts master-clock pin edges.
// Assumes a single mclk domain; sources change just after rising edges.
module amc_codec_model #(
	parameter int H1 = 2,
	parameter int H2 = 3,
	parameter int HE = 4
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Pins received and count clear.
	input wire logic pin1,
	input wire logic pin2,
	input wire logic clr,
	// Source levels and edge counts.
	output logic syn1,
	output logic syn2,
	output logic ext,
	output int cnt1,
	output int cnt2
);
	timeunit 1ns;
	timeprecision 1ps;
	int t;
	logic p1;
	logic p2;

	// Square waves of fixed half period, so every legal high phase lasts two mclk cycles or more.
	assign syn1 = 1'((t / H1) % 2);
	assign syn2 = 1'((t / H2) % 2);
	assign ext = 1'((t / HE) % 2);

	// Edge counters stand for the codec's view of each received clock.
	always_ff @(posedge mclk)
	begin
		t <= rst_n ? t + 1 : 0;
		p1 <= pin1;
		p2 <= pin2;
		cnt1 <= clr ? 0 : cnt1 + int'(pin1 & ~p1);
		cnt2 <= clr ? 0 : cnt2 + int'(pin2 & ~p2);
	end
endmodule : amc_codec_model

/* File: tb/amc_top_tb_top.sv */
// Testbench for the master-clock select and divide block, driven through its register bus.
// Assumes the codec model supplies the source clocks; pin rates are judged from edge counts.
module amc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 2048;
	logic mclk = 0, rst_n = 0, mcu_wr = 0, mcu_rd = 0, sof = 0, use2 = 0, clr = 0;
	logic [15:0] mcu_addr = 16'h0000;
	logic [7:0] mcu_wdata = 8'h00;
	logic [7:0] mcu_rdata;
	logic [23:0] fword;
	logic syn1, syn2, ext, pin1, pin2;
	logic [2:0] s1 = 3'h0, s2 = 3'h0;
	int cnt1, cnt2, runts = 0, n_fail = 0, checked = 0;
	logic [15:0] adr [4] = '{16'hffe1, 16'hffe2, 16'hfff6, 16'hfff7};
	logic [7:0] msk [4] = '{8'hdf, 8'hf7, 8'hf0, 8'hff};
	// Columns: control, div1, div2, half period and code for pin 1, then for pin 2; half period 0 means silent.
	int rows [10][7] = '{
		'{8'hc4, 8'h00, 8'h00, 2, 0, 2, 0},
		'{8'hc4, 8'hf0, 8'h00, 2, 15, 2, 15},
		'{8'hd6, 8'h00, 8'hf0, 3, 15, 3, 15},
		'{8'hd6, 8'h00, 8'h00, 3, 0, 3, 0},
		'{8'hcd, 8'h07, 8'h00, 4, 7, 4, 7},
		'{8'hdf, 8'h00, 8'h00, 4, 0, 4, 0},
		'{8'hd5, 8'h52, 8'h30, 3, 3, 4, 2},
		'{8'hc0, 8'h00, 8'h00, 0, 0, 0, 0},
		'{8'h44, 8'h00, 8'h00, 2, 0, 0, 0},
		'{8'h84, 8'h00, 8'h00, 0, 0, 2, 0}
	};

	amc_top dut_u (.mclk(mclk), .rst_n(rst_n), .mcu_addr(mcu_addr), .mcu_wr(mcu_wr), .mcu_rd(mcu_rd),
		.mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata), .first_synth_clock(syn1), .second_synth_clock(syn2),
		.ext_master_clock_in(ext), .usb_sof(sof), .capture_use_second(use2), .second_synth_freq_word(fword),
		.first_master_clock_out(pin1), .second_master_clock_out(pin2));
	amc_codec_model codec_u (.mclk(mclk), .rst_n(rst_n), .pin1(pin1), .pin2(pin2), .clr(clr),
		.syn1(syn1), .syn2(syn2), .ext(ext), .cnt1(cnt1), .cnt2(cnt2));

	// Clock generator.
	initial
	begin
		forever #2 mclk = ~mclk;
	end

	// A one-cycle high phase cannot come from any source here, so it marks a switching glitch.
	always @(posedge mclk)
	begin
		s1 <= {s1[1:0], pin1};
		s2 <= {s2[1:0], pin2};
		if (rst_n && (s1 == 3'b010 || s2 == 3'b010))
			runts <= runts + 1;
	end

	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_cnt(string what, int exp, int got, int tol);
		checked++;
		if (got < exp - tol || got > exp + tol)
		begin
			n_fail++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt

	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge mclk);
		mcu_addr <= a;
		mcu_wdata <= d;
		mcu_wr <= 1'b1;
		@(posedge mclk);
		mcu_wr <= 1'b0;
	endtask : wr

	// Read data is taken in the cycle after the edge that takes the read.
	task automatic rd(logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		mcu_addr <= a;
		mcu_rd <= 1'b1;
		@(posedge mclk);
		mcu_rd <= 1'b0;
		@(negedge mclk);
		d = mcu_rdata;
	endtask : rd

	task automatic rchk(string what, logic [15:0] a, logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, 24'(exp), 24'(d));
	endtask : rchk

	// Marks a frame, restarting the codec count, and returns the capture and the count before it.
	task automatic frame(output logic [15:0] c, output int n);
		logic [7:0] hi;
		logic [7:0] lo;
		@(negedge mclk);
		n = use2 ? cnt2 : cnt1;
		@(posedge mclk);
		sof <= 1'b1;
		clr <= 1'b1;
		@(posedge mclk);
		sof <= 1'b0;
		clr <= 1'b0;
		rd(16'hffe3, hi);
		rd(16'hffe4, lo);
		c = {hi, lo};
	endtask : frame

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Watchdog: the whole run needs about 26000 cycles.
	initial
	begin
		#200us;
		n_fail++;
		end_of_test();
	end

	initial
	begin
		logic [15:0] ca;
		logic [15:0] cb;
		int n;
		int e;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (adr[i])
		begin
			rchk("reset value", adr[i], 8'h00);
			wr(adr[i], 8'hff);
			rchk("writable bits", adr[i], msk[i]);
		end
		wr(16'h1234, 8'hff);
		rchk("unmapped", 16'h1234, 8'h00);
		wr(16'hffe3, 8'hff);
		rchk("capture read only", 16'hffe3, 8'h00);
		wr(16'hfff7, 8'ha5);
		wr(16'hfff8, 8'h3c);
		wr(16'hfff9, 8'h96);
		@(negedge mclk);
		chk("frequency word", 24'ha53c96, fword);
		$display("test registers done");
		// Rows change source and ratio while clocks run, which also exercises glitch-free switching.
		foreach (rows[i])
		begin
			wr(16'hffe2, 8'(rows[i][1]));
			wr(16'hfff6, 8'(rows[i][2]));
			wr(16'hffe1, 8'(rows[i][0]));
			repeat (300) @(posedge mclk);
			@(posedge mclk);
			clr <= 1'b1;
			@(posedge mclk);
			clr <= 1'b0;
			repeat (W) @(posedge mclk);
			@(negedge mclk);
			e = rows[i][3] ? W / (2 * rows[i][3] * (rows[i][4] + 1)) : 0;
			chk_cnt("first pin edges", e, cnt1, rows[i][3] ? 2 : 0);
			e = rows[i][5] ? W / (2 * rows[i][5] * (rows[i][6] + 1)) : 0;
			chk_cnt("second pin edges", e, cnt2, rows[i][5] ? 2 : 0);
			$display("test divider row %0d done", i);
		end
		wr(16'hffe1, 8'h44);
		frame(ca, n);
		repeat (1000) @(posedge mclk);
		frame(cb, n);
		chk_cnt("capture on first pin", n, int'(cb - ca), 2);
		wr(16'hffe1, 8'hc6);
		@(posedge mclk);
		use2 <= 1'b1;
		frame(ca, n);
		repeat (1000) @(posedge mclk);
		frame(cb, n);
		chk_cnt("capture on second pin", n, int'(cb - ca), 2);
		$display("test capture done");
		chk_cnt("runt pulses", 0, runts, 0);
		end_of_test();
	end
endmodule : amc_top_tb_top
